/* rtl/hss_pkg.sv */
// constants and carrier types for the hot swap status and fault registers
// Summary of operation
// - system status bit 7 is 1 while the switch gate is commanded on
// - system status bit 6 follows the active-low enable pin level
// - system status bits 5 and 4 show second and first gate drive pins
// - system status bit 3 is 1 while the timer pin is below 0.1V
// - system status bit 2 is 1 during a non-volatile write
// - system status bit 1 shows the power good condition
// - system status bit 0 shows the single driver mode
// - converter status bits 7:4 label the auxiliary input last converted
// - converter status bit 3 is 1 only when idle in snapshot mode
// - converter status bits 2:0 show parallel, high and low stress staged modes
// - pin levels: bits 7:4 power good pins 1-4, bits 3:0 analog pins 1-4
// - live fault bit 7 is 1 when pin four sits at its asserted level
// - live fault bit 6 is 1 while a switch short is detected
// - live fault bit 5 is 1 while output is below threshold
// - live fault bit 4 holds power good input badness caught at timer expiry
// - live fault bit 3 is 1 while the switch is degraded
// - live fault bit 2 is 1 while current limiting is active
// - live fault bit 1 is 1 only when both undervoltage inputs are low
// - live fault bit 0 is 1 when the overvoltage input is high
// - latched fault flags reset to zero and set on each event
// - latched bit 5 sets when output is low after power good latched
package hss_pkg;
	localparam logic [7:0] HSS_OFS_SYSTEM_STATUS = 8'h00;
	localparam logic [7:0] HSS_OFS_CONVERTER_STATUS = 8'h01;
	localparam logic [7:0] HSS_OFS_PIN_INPUT_LEVELS = 8'h02;
	localparam logic [7:0] HSS_OFS_LIVE_FAULT = 8'h03;
	localparam logic [7:0] HSS_OFS_LATCHED_FAULT = 8'h04;
	localparam logic [7:0] HSS_FLAGS_RESET = 8'h00;
	localparam logic [7:0] HSS_RD_RESET = 8'h00;
	localparam logic [7:0] HSS_UNMAPPED_READ = 8'hFF;
	// latched and live fault bit positions, then the converter status idle bit
	localparam int HSS_BIT_EXT = 7;
	localparam int HSS_BIT_SHORT = 6;
	localparam int HSS_BIT_VOUT = 5;
	localparam int HSS_BIT_PGI = 4;
	localparam int HSS_BIT_BAD = 3;
	localparam int HSS_BIT_OC = 2;
	localparam int HSS_BIT_UV = 1;
	localparam int HSS_BIT_HIGH_LIMIT = 0;
	localparam int HSS_BIT_ADC_IDLE = 3;

	typedef struct packed {
		logic enable_n_level;
		logic second_fet_drive_pin;
		logic first_fet_drive_pin;
		logic fault_timer_below;
		logic [1:4] general_power_good_pins;
		logic [1:4] analog_digital_pins;
		logic under_thresh_high_input;
		logic under_thresh_low_input;
		logic input_high_limit_cmp;
	} hss_pins_s;

	localparam int HSS_PIN_W = $bits(hss_pins_s);

	typedef struct packed {
		logic switch_commanded_on;
		logic nv_write_busy;
		logic power_good_flag;
		logic single_driver_mode_flag;
		logic parallel_mode_flag;
		logic high_stress_staged_flag;
		logic low_stress_staged_flag;
		logic [3:0] last_aux_channel_label;
		logic adc_snapshot_mode;
		logic adc_busy;
		logic external_fault_latched_active_high;
		logic switch_short_live;
		logic output_below_threshold;
		logic power_good_latched;
		logic pgi_check_expired;
		logic pgi_good_high;
		logic switch_degraded_live;
		logic current_limit_active;
		logic overcurrent_fault_event;
	} hss_core_s;

	typedef struct packed {
		logic rd_en;
		logic wr_en;
		logic [7:0] addr;
		logic [7:0] wr_data;
	} hss_req_s;

	typedef struct packed {
		hss_pins_s s1;
		hss_pins_s s2;
		hss_pins_s s3;
		hss_pins_s filt;
		logic pgi_bad;
		logic [7:0] flags;
		logic [7:0] rd_data;
	} hss_state_s;
endpackage

/* rtl/hss_regs.sv */
// status, live fault and latched fault registers of the hot swap controller
`timescale 1ns/1ps
`default_nettype none
module hss_regs
	import hss_pkg::*;
(
	input wire logic clock,
	input wire logic srst,
	input wire hss_pins_s pins,
	input wire hss_core_s core,
	input wire hss_req_s req,
	output logic [7:0] rd_data,
	output logic [7:0] latched_fault_flags
);
	hss_state_s state_reg;
	hss_state_s state_next;
	logic [7:0] sys_v;
	logic [7:0] adc_v;
	logic [7:0] pin_v;
	logic [7:0] live_v;
	logic [7:0] set_v;
	logic flag_wr;

	// a bit moves only once the second and third stages agree
	function automatic hss_pins_s filt_step(input hss_pins_s a, input hss_pins_s b, input hss_pins_s f);
		logic [HSS_PIN_W-1:0] agree;
		agree = ~(a ^ b);
		return hss_pins_s'((a & agree) | (f & ~agree));
	endfunction

	always_comb begin
		sys_v = {core.switch_commanded_on,
			state_reg.filt.enable_n_level,
			state_reg.filt.second_fet_drive_pin, state_reg.filt.first_fet_drive_pin,
			state_reg.filt.fault_timer_below,
			core.nv_write_busy,
			core.power_good_flag,
			core.single_driver_mode_flag};
		adc_v = {core.last_aux_channel_label,
			core.adc_snapshot_mode & ~core.adc_busy,
			core.parallel_mode_flag, core.high_stress_staged_flag, core.low_stress_staged_flag};
		pin_v = {state_reg.filt.general_power_good_pins, state_reg.filt.analog_digital_pins};
		live_v = '0;
		live_v[HSS_BIT_EXT] = state_reg.filt.general_power_good_pins[4] == core.external_fault_latched_active_high;
		live_v[HSS_BIT_SHORT] = core.switch_short_live;
		live_v[HSS_BIT_VOUT] = core.output_below_threshold;
		live_v[HSS_BIT_PGI] = state_reg.pgi_bad;
		live_v[HSS_BIT_BAD] = core.switch_degraded_live;
		live_v[HSS_BIT_OC] = core.current_limit_active;
		live_v[HSS_BIT_UV] = ~state_reg.filt.under_thresh_high_input & ~state_reg.filt.under_thresh_low_input;
		live_v[HSS_BIT_HIGH_LIMIT] = state_reg.filt.input_high_limit_cmp;
		// overcurrent latches on the core's fault event, not on brief limiting
		set_v = live_v;
		set_v[HSS_BIT_VOUT] = core.output_below_threshold & core.power_good_latched;
		set_v[HSS_BIT_PGI] = state_reg.pgi_bad;
		set_v[HSS_BIT_OC] = core.overcurrent_fault_event;
	end

	assign flag_wr = req.wr_en && req.addr == HSS_OFS_LATCHED_FAULT;

	always_comb begin
		state_next = state_reg;
		state_next.s1 = pins;
		state_next.s2 = state_reg.s1;
		state_next.s3 = state_reg.s2;
		state_next.filt = filt_step(state_reg.s2, state_reg.s3, state_reg.filt);
		if (core.pgi_check_expired) begin
			state_next.pgi_bad = state_reg.filt.general_power_good_pins[3] != core.pgi_good_high;
		end
		// writing 1 keeps a flag, writing 0 clears it; a new event wins the clear
		if (flag_wr) begin
			state_next.flags = (state_reg.flags & req.wr_data) | set_v;
		end else begin
			state_next.flags = state_reg.flags | set_v;
		end
		if (req.rd_en) begin
			case (req.addr)
				HSS_OFS_SYSTEM_STATUS: state_next.rd_data = sys_v;
				HSS_OFS_CONVERTER_STATUS: state_next.rd_data = adc_v;
				HSS_OFS_PIN_INPUT_LEVELS: state_next.rd_data = pin_v;
				HSS_OFS_LIVE_FAULT: state_next.rd_data = live_v;
				HSS_OFS_LATCHED_FAULT: state_next.rd_data = state_reg.flags;
				default: state_next.rd_data = HSS_UNMAPPED_READ;
			endcase
		end
	end

	always_ff @(posedge clock) begin
		if (srst) begin
			state_reg <= '0;
			state_reg.flags <= HSS_FLAGS_RESET;
			state_reg.rd_data <= HSS_RD_RESET;
		end else begin
			state_reg <= state_next;
		end
	end

	assign rd_data = state_reg.rd_data;
	assign latched_fault_flags = state_reg.flags;

	default clocking cb @(posedge clock); endclocking
	default disable iff (srst);

	// latched flags; the first edge after reset sees pre-reset history, so those checks skip it
	a_flag_sticky_hold: assert property (
		!$past(srst) && !$past(flag_wr)
		|-> (state_reg.flags & $past(state_reg.flags)) == $past(state_reg.flags))
		else $error("latched flag dropped without a write");

	a_no_phantom_flag: assert property (
		!$past(srst)
		|-> (state_reg.flags & ~$past(state_reg.flags) & ~$past(set_v)) == 8'h00)
		else $error("flag set with no event");

	a_event_sets_flag: assert property (
		!$past(srst)
		|-> ($past(set_v) & ~state_reg.flags) == 8'h00)
		else $error("event did not set its flag");

	a_zero_write_clears: assert property (
		flag_wr && req.wr_data == 8'h00 && set_v == 8'h00
		|=> state_reg.flags == 8'h00)
		else $error("zero write did not clear flags");

	a_flag_idle_update: assert property (
		!flag_wr
		|=> state_reg.flags == ($past(state_reg.flags) | $past(set_v)))
		else $error("flags changed wrongly without a write");

	a_flag_write_update: assert property (
		flag_wr
		|=> state_reg.flags == (($past(state_reg.flags) & $past(req.wr_data)) | $past(set_v)))
		else $error("flags changed wrongly on a write");

	a_power_fail_latch: assert property (
		core.output_below_threshold && core.power_good_latched
		|=> state_reg.flags[HSS_BIT_VOUT])
		else $error("output_dropped_latched flag not set");

	a_power_fail_quiet: assert property (
		!(core.output_below_threshold && core.power_good_latched) && !state_reg.flags[HSS_BIT_VOUT]
		|=> !state_reg.flags[HSS_BIT_VOUT])
		else $error("output_dropped_latched flag set without a drop");

	a_oc_event_latch: assert property (
		core.overcurrent_fault_event
		|=> state_reg.flags[HSS_BIT_OC])
		else $error("overcurrent flag not set");

	a_pgi_flag_tracks: assert property (
		state_reg.pgi_bad
		|=> state_reg.flags[HSS_BIT_PGI])
		else $error("power good input flag not set");

	// read data, one cycle after the read strobe
	a_sys_read_data: assert property (
		req.rd_en && req.addr == HSS_OFS_SYSTEM_STATUS
		|=> rd_data == $past(sys_v))
		else $error("system status read mismatch");

	a_sys_gate_bit: assert property (
		req.rd_en && req.addr == HSS_OFS_SYSTEM_STATUS
		|=> rd_data[7] == $past(core.switch_commanded_on))
		else $error("commanded on bit wrong");

	a_sys_enable_bit: assert property (
		req.rd_en && req.addr == HSS_OFS_SYSTEM_STATUS
		|=> rd_data[6] == $past(state_reg.filt.enable_n_level))
		else $error("enable pin bit wrong");

	a_sys_drive_bits: assert property (
		req.rd_en && req.addr == HSS_OFS_SYSTEM_STATUS
		|=> rd_data[5:4] == $past({state_reg.filt.second_fet_drive_pin, state_reg.filt.first_fet_drive_pin}))
		else $error("drive pin bits wrong");

	a_sys_timer_bit: assert property (
		req.rd_en && req.addr == HSS_OFS_SYSTEM_STATUS
		|=> rd_data[3] == $past(state_reg.filt.fault_timer_below))
		else $error("timer pin bit wrong");

	a_nv_busy_bit: assert property (
		req.rd_en && req.addr == HSS_OFS_SYSTEM_STATUS
		|=> rd_data[2] == $past(core.nv_write_busy))
		else $error("write busy bit wrong");

	a_sys_power_good: assert property (
		req.rd_en && req.addr == HSS_OFS_SYSTEM_STATUS
		|=> rd_data[1] == $past(core.power_good_flag))
		else $error("power good bit wrong");

	a_sys_single_mode: assert property (
		req.rd_en && req.addr == HSS_OFS_SYSTEM_STATUS
		|=> rd_data[0] == $past(core.single_driver_mode_flag))
		else $error("single driver bit wrong");

	a_adc_label_read: assert property (
		req.rd_en && req.addr == HSS_OFS_CONVERTER_STATUS
		|=> rd_data[7:4] == $past(core.last_aux_channel_label))
		else $error("channel label wrong");

	a_adc_idle_bit: assert property (
		adc_v[HSS_BIT_ADC_IDLE]
		|-> core.adc_snapshot_mode && !core.adc_busy)
		else $error("idle shown outside snapshot idle");

	a_adc_idle_read: assert property (
		req.rd_en && req.addr == HSS_OFS_CONVERTER_STATUS
		|=> rd_data[HSS_BIT_ADC_IDLE] == $past(core.adc_snapshot_mode && !core.adc_busy))
		else $error("idle bit read wrong");

	a_adc_mode_bits: assert property (
		req.rd_en && req.addr == HSS_OFS_CONVERTER_STATUS
		|=> rd_data[2:0] == $past({core.parallel_mode_flag, core.high_stress_staged_flag, core.low_stress_staged_flag}))
		else $error("mode bits wrong");

	a_pin_level_read: assert property (
		req.rd_en && req.addr == HSS_OFS_PIN_INPUT_LEVELS
		|=> rd_data == $past({state_reg.filt.general_power_good_pins, state_reg.filt.analog_digital_pins}))
		else $error("pin levels wrong");

	a_live_ext_read: assert property (
		req.rd_en && req.addr == HSS_OFS_LIVE_FAULT
		|=> rd_data[HSS_BIT_EXT] == $past(state_reg.filt.general_power_good_pins[4] == core.external_fault_latched_active_high))
		else $error("external fault level wrong");

	a_live_short_read: assert property (
		req.rd_en && req.addr == HSS_OFS_LIVE_FAULT
		|=> rd_data[HSS_BIT_SHORT] == $past(core.switch_short_live))
		else $error("short level wrong");

	a_live_vout_read: assert property (
		req.rd_en && req.addr == HSS_OFS_LIVE_FAULT
		|=> rd_data[HSS_BIT_VOUT] == $past(core.output_below_threshold))
		else $error("output low level wrong");

	a_live_pgi_read: assert property (
		req.rd_en && req.addr == HSS_OFS_LIVE_FAULT
		|=> rd_data[HSS_BIT_PGI] == $past(state_reg.pgi_bad))
		else $error("power good input level wrong");

	a_live_bad_read: assert property (
		req.rd_en && req.addr == HSS_OFS_LIVE_FAULT
		|=> rd_data[HSS_BIT_BAD] == $past(core.switch_degraded_live))
		else $error("degraded level wrong");

	a_live_oc_read: assert property (
		req.rd_en && req.addr == HSS_OFS_LIVE_FAULT
		|=> rd_data[HSS_BIT_OC] == $past(core.current_limit_active))
		else $error("current limit level wrong");

	a_live_uv_read: assert property (
		req.rd_en && req.addr == HSS_OFS_LIVE_FAULT
		|=> rd_data[HSS_BIT_UV] == $past(!state_reg.filt.under_thresh_high_input
			&& !state_reg.filt.under_thresh_low_input))
		else $error("undervoltage level read wrong");

	a_live_ov_read: assert property (
		req.rd_en && req.addr == HSS_OFS_LIVE_FAULT
		|=> rd_data[HSS_BIT_HIGH_LIMIT] == $past(state_reg.filt.input_high_limit_cmp))
		else $error("overvoltage level wrong");

	a_uv_both_low: assert property (
		live_v[HSS_BIT_UV] == !(state_reg.filt.under_thresh_high_input || state_reg.filt.under_thresh_low_input))
		else $error("undervoltage live bit wrong");

	a_flag_read: assert property (
		req.rd_en && req.addr == HSS_OFS_LATCHED_FAULT
		|=> rd_data == $past(state_reg.flags))
		else $error("latched flags read wrong");

	a_unmapped_read: assert property (
		req.rd_en && req.addr > HSS_OFS_LATCHED_FAULT
		|=> rd_data == HSS_UNMAPPED_READ)
		else $error("unmapped read not all ones");

	a_read_data_holds: assert property (
		!req.rd_en
		|=> $stable(rd_data))
		else $error("read data moved without a read");

	// pin synchronisers and the captured check result
	a_pgi_capture: assert property (
		core.pgi_check_expired
		|=> state_reg.pgi_bad == $past(state_reg.filt.general_power_good_pins[3] != core.pgi_good_high))
		else $error("power good input check not captured");

	a_pgi_hold: assert property (
		!core.pgi_check_expired
		|=> $stable(state_reg.pgi_bad))
		else $error("check result moved without expiry");

	a_pin_filter: assert property (
		!$past(srst)
		|-> ((state_reg.filt ^ $past(state_reg.filt)) & ($past(state_reg.s2) ^ $past(state_reg.s3))) == '0)
		else $error("pin level moved before stages agreed");

	a_pin_settle: assert property (
		!$past(srst) && !$past(srst, 2) && !$past(srst, 3) && !$past(srst, 4)
			&& pins == $past(pins) && pins == $past(pins, 2) && pins == $past(pins, 3) && pins == $past(pins, 4)
		|-> state_reg.filt == pins)
		else $error("steady pin level not taken");

	a_reset_clears: assert property (
		disable iff (1'b0) srst
		|=> state_reg.flags == HSS_FLAGS_RESET && rd_data == HSS_RD_RESET)
		else $error("reset did not clear registers");
endmodule
`default_nettype wire

/* testbench/hot_swap_status_fault_regs_test.sv */
// self-checking bench for the hot swap status and fault registers
`timescale 1ns/1ps
`default_nettype none
module hot_swap_status_fault_regs_test import hss_pkg::*; ;
	typedef struct packed {
		hss_pins_s p;
		hss_core_s c;
	} hss_row_s;
	logic clock = 1'b0;
	logic srst = 1'b1;
	hss_pins_s pins = 15'h0004;
	hss_core_s core = '0;
	hss_req_s req = '0;
	logic [7:0] rd_data;
	logic [7:0] latched_fault_flags;
	int bad_count = 0;
	int cmp_count = 0;
	int cyc = 0;
	logic [7:0] exp_flags;
	hss_pins_s prev;
	// pulse inputs (timer expiry, overcurrent event) stay 0 in rows
	hss_row_s rows [4] = '{{15'h7FFF, 22'h3FFFEE}, {15'h0000, 22'h0}, {15'h5555, 22'h2AAAAA}, {15'h2AAA, 22'h155544}};
	hss_regs uut (.clock(clock), .srst(srst), .pins(pins), .core(core), .req(req), .rd_data(rd_data),
		.latched_fault_flags(latched_fault_flags));
	initial forever #2.5 clock = ~clock;
	function automatic logic [7:0] expv(hss_pins_s p, hss_core_s c, logic [7:0] a);
		case (a)
			8'h00: return {c.switch_commanded_on, p.enable_n_level, p.second_fet_drive_pin, p.first_fet_drive_pin,
				p.fault_timer_below, c.nv_write_busy, c.power_good_flag, c.single_driver_mode_flag};
			8'h01: return {c.last_aux_channel_label, c.adc_snapshot_mode & ~c.adc_busy, c.parallel_mode_flag,
				c.high_stress_staged_flag, c.low_stress_staged_flag};
			8'h02: return {p.general_power_good_pins, p.analog_digital_pins};
			default: return {p.general_power_good_pins[4] == c.external_fault_latched_active_high, c.switch_short_live,
				c.output_below_threshold, 1'b0, c.switch_degraded_live, c.current_limit_active,
				~(p.under_thresh_high_input | p.under_thresh_low_input), p.input_high_limit_cmp};
		endcase
	endfunction
	function automatic logic [7:0] setf(hss_pins_s p, hss_core_s c);
		logic [7:0] v;
		v = expv(p, c, 8'h03);
		v[5] = c.output_below_threshold & c.power_good_latched;
		v[2] = c.overcurrent_fault_event;
		return v;
	endfunction
	task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
		cmp_count++;
		if (seen !== exp) begin
			bad_count++;
			$display("BAD %0t seen %h expected %h", $time, seen, exp);
		end
	endtask
	task automatic rd(input logic [7:0] a, input logic [7:0] e);
		@(negedge clock);
		req.rd_en = 1'b1;
		req.addr = a;
		@(negedge clock);
		req.rd_en = 1'b0;
		chk(rd_data, e);
	endtask
	task automatic wr(input logic [7:0] a, input logic [7:0] d);
		@(negedge clock);
		req.wr_en = 1'b1;
		req.addr = a;
		req.wr_data = d;
		@(negedge clock);
		req.wr_en = 1'b0;
	endtask
	task automatic test_done;
		if (bad_count == 0 && cmp_count > 0) begin
			$display("bench passed");
		end else begin
			$display("bench failed");
		end
		$finish;
	endtask
	always @(posedge clock) begin
		cyc++;
		if (cyc == 3000) begin
			bad_count++;
			test_done;
		end
	end
	initial begin
		repeat (20) @(negedge clock);
		chk(latched_fault_flags, HSS_FLAGS_RESET);
		chk(rd_data, HSS_RD_RESET);
		srst = 1'b0;
		// synchronisers read 0 just after reset, so the undervoltage flag sets at once
		exp_flags = 8'h02;
		prev = pins;
		foreach (rows[i]) begin
			pins = rows[i].p;
			core = rows[i].c;
			// pins lag the core levels, so old pins with new core can also set flags
			exp_flags |= setf(prev, core) | setf(pins, core);
			prev = pins;
			repeat (6) @(negedge clock);
			rd(8'h00, expv(pins, core, 8'h00));
			rd(8'h01, expv(pins, core, 8'h01));
			rd(8'h02, expv(pins, core, 8'h02));
			rd(8'h03, expv(pins, core, 8'h03));
			rd(8'h04, exp_flags);
		end
		pins = 15'h0004;
		core = 22'h000100;
		repeat (6) @(negedge clock);
		wr(8'h04, 8'h00);
		rd(8'h04, 8'h00);
		wr(8'h04, 8'hFF);
		rd(8'h04, 8'h00);
		wr(8'h00, 8'hFF);
		rd(8'h00, 8'h00);
		rd(8'h05, HSS_UNMAPPED_READ);
		core.output_below_threshold = 1'b1;
		repeat (3) @(negedge clock);
		chk(latched_fault_flags, 8'h00);
		core.power_good_latched = 1'b1;
		@(negedge clock);
		chk(latched_fault_flags, 8'h20);
		core.overcurrent_fault_event = 1'b1;
		@(negedge clock);
		core.overcurrent_fault_event = 1'b0;
		rd(8'h03, 8'h20);
		rd(8'h04, 8'h24);
		core = 22'h000108;
		wr(8'h04, 8'h00);
		core.pgi_check_expired = 1'b1;
		@(negedge clock);
		core.pgi_check_expired = 1'b0;
		wr(8'h04, 8'h00);
		rd(8'h03, 8'h10);
		rd(8'h04, 8'h10);
		pins.general_power_good_pins[3] = 1'b1;
		repeat (6) @(negedge clock);
		core.pgi_check_expired = 1'b1;
		@(negedge clock);
		core.pgi_check_expired = 1'b0;
		wr(8'h04, 8'h00);
		rd(8'h03, 8'h00);
		rd(8'h04, 8'h00);
		for (int k = 0; k < 16; k++) begin
			core.last_aux_channel_label = 4'(k);
			rd(8'h01, {4'(k), 4'h0});
		end
		core.switch_short_live = 1'b1;
		repeat (2) @(negedge clock);
		srst = 1'b1;
		repeat (4) @(negedge clock);
		chk(latched_fault_flags, HSS_FLAGS_RESET);
		chk(rd_data, HSS_RD_RESET);
		test_done;
	end
endmodule
`default_nettype wire
